// file: rtl/oasp_consts.vh
// constants for the octal converter serial port
`ifndef OASP_CONSTS_VH
`define OASP_CONSTS_VH
`define OASP_CTRL_W 8
`define OASP_CHAN_MSB 5
`define OASP_CHAN_LSB 3
`define OASP_CHAN_RST 3'h0
`define OASP_RES_W 10
`define OASP_FRAME_LEN 5'h10
`define OASP_TRACK_END 5'h03
`define OASP_RES_FIRST 5'h05
`define OASP_RES_LAST 5'h0E
`define OASP_CTRL_BITS 5'h08
`define OASP_DBUF_DEPTH 2
`endif

// file: rtl/oasp_sync2.v
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module oasp_sync2 #(
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // level in and out
   input wire d_in,
   output reg q_out
);
   reg meta_r;
   // ====================
   // synchroniser
   always @(posedge mclk) begin
      if (!reset_n) begin
         meta_r <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// file: rtl/oasp_serial_port.v
// control logic and serial port of the octal 10-bit converter
// How it works
// - a frame runs from chip select fall to rise; the fall starts a conversion if the clock is low
// - serial_out is driven only while chip select is low
// - serial clock is ignored while chip select is high
// - track for three clocks, then hold and convert for thirteen
// - falls 1-4 zeros, 5-14 result msb first, 15-16 zeros
// - back to track on the first fall after each sixteenth rise; hold again on fourth fall
// - select falling with clock high: tracking starts on next clock fall
// - select falling with clock low: the fall counts as first clock fall
// - first eight rising edges of each conversion load the control word
// - a loaded channel code applies to the next conversion only
// - control bits 7, 6, 2, 1 and 0 are ignored
// - bits 5..3 pick channel 0 to 7 as unsigned binary
// - channel field resets to zero; first conversion uses input 0
// - result is straight binary, 1024 codes, supplied by the analog core
// - powered while select low, but down between a 16th and next 1st fall
`timescale 1ns/10ps
`default_nettype none
`include "oasp_consts.vh"
module oasp_serial_port #(
   parameter RES_W = `OASP_RES_W,
   parameter DBUF_DEPTH = `OASP_DBUF_DEPTH
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // serial pins
   input wire chip_select_n,
   input wire serial_clk,
   input wire serial_in,
   output reg serial_out_o,
   output reg serial_out_oe,
   // analog core
   input wire [RES_W-1:0] conv_result,
   input wire conv_valid,
   output reg conv_ready,
   output reg [2:0] channel_sel,
   output reg track_mode,
   output reg powered_up,
   output reg result_lost
);
   // ====================
   // pin synchronisers
   wire cs_n_s;
   wire sclk_s;
   wire sdi_s;
   oasp_sync2 #(.RST_VAL(1'b1)) u_sync_cs (.mclk(mclk), .reset_n(reset_n),
      .d_in(chip_select_n), .q_out(cs_n_s));
   oasp_sync2 #(.RST_VAL(1'b0)) u_sync_clk (.mclk(mclk), .reset_n(reset_n),
      .d_in(serial_clk), .q_out(sclk_s));
   oasp_sync2 #(.RST_VAL(1'b0)) u_sync_sdi (.mclk(mclk), .reset_n(reset_n),
      .d_in(serial_in), .q_out(sdi_s));

   reg cs_n_d_r;
   reg sclk_d_r;
   always @(posedge mclk) begin
      if (!reset_n) begin
         cs_n_d_r <= 1'b1;
         sclk_d_r <= 1'b0;
      end else begin
         cs_n_d_r <= cs_n_s;
         sclk_d_r <= sclk_s;
      end
   end
   wire cs_fall = cs_n_d_r & ~cs_n_s;
   // clock edges only count inside a frame
   wire sclk_rise = ~cs_n_s & ~cs_n_d_r & sclk_s & ~sclk_d_r;
   wire sclk_fall_raw = ~cs_n_s & ~cs_n_d_r & ~sclk_s & sclk_d_r;
   // select falling with clock low is taken as the first clock fall
   wire cs_as_fall = cs_fall & ~sclk_s;
   wire sclk_fall = sclk_fall_raw | cs_as_fall;

   // ====================
   // edge counters
   // fall_cnt_r: falls seen in this conversion, 0..16
   // rise_cnt_r: rises seen in this conversion, 0..16
   localparam ST_IDLE = 3'b001;
   localparam ST_TRACK = 3'b010;
   localparam ST_HOLD = 3'b100;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [4:0] fall_cnt_r;
   reg [4:0] rise_cnt_r;
   reg [`OASP_CTRL_W-1:0] ctrl_shift_r;
   reg [RES_W-1:0] out_shift_r;
   reg pend_load_r;

   // ====================
   // two-entry result buffer
   // the analog core may finish early; a full buffer stalls it, not drops
   reg [RES_W-1:0] buf_mem [0:DBUF_DEPTH-1];
   reg buf_wp_r;
   reg buf_rp_r;
   reg [1:0] buf_cnt_r;
   wire buf_empty = (buf_cnt_r == 2'h0);
   // a word is taken only while ready stands, so ready must see the
   // count that this edge leaves behind
   wire buf_push = conv_valid & conv_ready;
   // drain side: the shifter takes a word at the fourth fall of a conversion
   wire load_point = sclk_fall & (fall_cnt_r == `OASP_TRACK_END);
   wire buf_pop = pend_load_r & ~buf_empty;
   wire [1:0] buf_cnt_nxt = buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
   always @(posedge mclk) begin
      if (!reset_n) begin
         buf_wp_r <= 1'b0;
         buf_rp_r <= 1'b0;
         buf_cnt_r <= 2'h0;
      end else begin
         if (buf_push) begin
            buf_mem[buf_wp_r] <= conv_result;
            buf_wp_r <= ~buf_wp_r;
         end
         if (buf_pop)
            buf_rp_r <= ~buf_rp_r;
         case ({buf_push, buf_pop})
            2'b10: buf_cnt_r <= buf_cnt_r + 2'h1;
            2'b01: buf_cnt_r <= buf_cnt_r - 2'h1;
            default: buf_cnt_r <= buf_cnt_r;
         endcase
      end
   end

   // ====================
   // track / hold sequencing
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (cs_as_fall)
               state_nxt = ST_TRACK;
         end
         ST_TRACK: begin
            if (sclk_fall & (fall_cnt_r == `OASP_TRACK_END))
               state_nxt = ST_HOLD;
         end
         ST_HOLD: begin
            if (sclk_fall & (fall_cnt_r == `OASP_FRAME_LEN))
               state_nxt = ST_TRACK;
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (state_r == ST_IDLE && sclk_fall_raw)
         state_nxt = ST_TRACK;
      if (cs_n_s)
         state_nxt = ST_IDLE;
   end

   always @(posedge mclk) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         fall_cnt_r <= 5'h00;
         rise_cnt_r <= 5'h00;
         ctrl_shift_r <= {`OASP_CTRL_W{1'b0}};
         channel_sel <= `OASP_CHAN_RST;
         out_shift_r <= {RES_W{1'b0}};
         pend_load_r <= 1'b0;
         serial_out_o <= 1'b0;
         serial_out_oe <= 1'b0;
         track_mode <= 1'b0;
         powered_up <= 1'b0;
         conv_ready <= 1'b0;
         result_lost <= 1'b0;
      end else begin
         state_r <= state_nxt;
         conv_ready <= (buf_cnt_nxt < DBUF_DEPTH);
         serial_out_oe <= ~cs_n_s;
         track_mode <= (state_nxt == ST_TRACK);
         if (cs_n_s) begin
            fall_cnt_r <= 5'h00;
            rise_cnt_r <= 5'h00;
            serial_out_o <= 1'b0;
            powered_up <= 1'b0;
            pend_load_r <= 1'b0;
         end else begin
            if (cs_fall)
               powered_up <= 1'b1;
            // ---- falling edges: count and shift out
            if (sclk_fall) begin
               if (fall_cnt_r == `OASP_FRAME_LEN) begin
                  fall_cnt_r <= 5'h01;
                  powered_up <= 1'b1;
               end else begin
                  fall_cnt_r <= fall_cnt_r + 5'h01;
               end
               if (fall_cnt_r == `OASP_FRAME_LEN - 5'h01)
                  powered_up <= 1'b0;
               // falls 1..4 and 15..16 give zeros
               if (fall_cnt_r >= `OASP_RES_FIRST - 5'h01 &&
                   fall_cnt_r <= `OASP_RES_LAST - 5'h01) begin
                  serial_out_o <= out_shift_r[RES_W-1];
                  out_shift_r <= {out_shift_r[RES_W-2:0], 1'b0};
               end else begin
                  serial_out_o <= 1'b0;
               end
            end
            if (load_point)
               pend_load_r <= 1'b1;
            if (buf_pop) begin
               out_shift_r <= buf_mem[buf_rp_r];
               pend_load_r <= 1'b0;
            end
            if (load_point & ~buf_pop & buf_empty)
               result_lost <= 1'b1;
            // ---- rising edges: control word
            if (sclk_rise) begin
               if (rise_cnt_r == `OASP_FRAME_LEN)
                  rise_cnt_r <= 5'h01;
               else
                  rise_cnt_r <= rise_cnt_r + 5'h01;
               if (rise_cnt_r < `OASP_CTRL_BITS || 
                   rise_cnt_r == `OASP_FRAME_LEN)
                  ctrl_shift_r <= {ctrl_shift_r[`OASP_CTRL_W-2:0],
                     sdi_s};
               // eighth bit in: take the channel for the next conversion
               if (rise_cnt_r == `OASP_CTRL_BITS - 5'h01)
                  channel_sel <= ctrl_shift_r[`OASP_CHAN_MSB-1:
                     `OASP_CHAN_LSB-1];
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: testbench/oasp_props.sv
// assertions on the converter serial port pins
`timescale 1ns/10ps
`default_nettype none
module oasp_props #(
   parameter RES_W = 10
) (
   input wire logic mclk, reset_n, chip_select_n, serial_clk, serial_in,
   input wire logic serial_out_o, serial_out_oe, conv_valid, conv_ready,
   input wire logic [RES_W-1:0] conv_result,
   input wire logic [2:0] channel_sel,
   input wire logic track_mode, powered_up, result_lost
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   oe_idle_a: assert property (
      chip_select_n [*6] |-> !serial_out_oe) else $error("oe idle");
   oe_frame_a: assert property (
      !chip_select_n [*6] |-> serial_out_oe) else $error("oe frame");
   track_idle_a: assert property (
      chip_select_n [*6] |-> !track_mode) else $error("track idle");
   power_idle_a: assert property (
      chip_select_n [*6] |-> !powered_up) else $error("power idle");
   track_len_a: assert property (
      $rose(track_mode) |-> track_mode [*8] ##[20:40] !track_mode)
      else $error("track length");
   lead_zero_a: assert property (
      track_mode && serial_out_oe |-> !serial_out_o) else $error("lead");
   out_steady_a: assert property (
      serial_out_oe && $past(serial_out_oe, 6) && serial_clk &&
      $past(serial_clk, 6) |-> $stable(serial_out_o)) else $error("out");
   chan_hold_a: assert property (
      track_mode && $past(track_mode) |-> $stable(channel_sel))
      else $error("chan");
   cover property ($rose(track_mode));
   cover property (conv_valid && !conv_ready);
   cover property ($rose(serial_out_o));
endmodule
bind oasp_serial_port oasp_props #(.RES_W(RES_W)) u_props (.*);
`default_nettype wire

// file: testbench/oasp_host_model.sv
// host model driving the serial pins
`timescale 1ns/10ps
`default_nettype none
module oasp_host_model (
   // frame request
   input wire logic go,
   input wire logic hi,
   input wire logic [1:0] nc,
   input wire logic [7:0] ctrl,
   // pins and captured words
   output logic cs_n = 1'b1,
   output logic sck = 1'b0,
   output logic sdi = 1'b0,
   input wire logic sdo,
   output logic [15:0] rx = 16'h0000,
   output logic done = 1'b0
);
   int c;
   int b;
   always @(posedge go) begin
      sck = hi;
      #40 cs_n = 1'b0;
      if (hi) #62.5;
      for (c = 0; c < nc; c++) begin
         for (b = 15; b >= 0; b--) begin
            if (sck) sck = 1'b0;
            sdi = (b > 7) ? ctrl[b-8] : ~sdi;
            #62.5 sck = 1'b1;
            rx = {rx[14:0], sdo};
            #62.5;
         end
         done = 1'b1;
         #1 done = 1'b0;
      end
      cs_n = 1'b1;
   end
endmodule
`default_nettype wire

// file: testbench/oasp_serial_port_tb.sv
// self-checking bench for the converter serial port
`timescale 1ns/10ps
`default_nettype none
module oasp_serial_port_tb;
   logic mclk = 1'b0, reset_n = 1'b0, go = 1'b0, hi = 1'b0, cv = 1'b0;
   logic [1:0] nc = 2'h1;
   logic [7:0] ctrl = 8'h00;
   logic [9:0] cr = 10'h000;
   logic [2:0] exp_ch = 3'h0;
   wire logic cs_n, sck, sdi, so_o, oe, rdy, tm, pu, lost, done, so;
   wire logic [15:0] rx;
   wire logic [2:0] ch;
   logic [15:0] q[$];
   logic [9:0] wq[$];
   integer n_mismatch = 0, checked = 0, seed = 32'h8DE3, cyc = 0, r;
   always #5 mclk = ~mclk;
   // released line shows the inverted bit, so sampling it is caught
   assign so = oe ? so_o : ~so_o;
   oasp_serial_port dut (
      .mclk(mclk), .reset_n(reset_n), .chip_select_n(cs_n),
      .serial_clk(sck), .serial_in(sdi), .serial_out_o(so_o),
      .serial_out_oe(oe), .conv_result(cr), .conv_valid(cv),
      .conv_ready(rdy), .channel_sel(ch), .track_mode(tm),
      .powered_up(pu), .result_lost(lost)
   );
   oasp_host_model host (
      .go(go), .hi(hi), .nc(nc), .ctrl(ctrl), .cs_n(cs_n), .sck(sck),
      .sdi(sdi), .sdo(so), .rx(rx), .done(done)
   );
   task end_sim;
      $display("compares %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         $display("Error at %0t: got %h exp %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   // core offers one word, held until taken
   task push;
      @(posedge mclk);
      r = $random(seed);
      cr <= r[9:0];
      cv <= 1'b1;
      wq.push_back(r[9:0]);
      do @(negedge mclk); while (rdy !== 1'b1);
      @(posedge mclk);
      cv <= 1'b0;
   endtask
   task frame(input logic [1:0] n, input logic [2:0] k);
      r = $random(seed);
      @(posedge mclk);
      ctrl <= {r[7:6], k, r[2:0]};
      hi <= r[8];
      nc <= n;
      repeat (n) q.push_back({4'h0, wq.pop_front(), 2'h0});
      @(posedge mclk);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (20) @(negedge mclk);
      cmp({13'h0, ch}, {13'h0, exp_ch});
      exp_ch = k;
      @(posedge cs_n);
      repeat (8) @(posedge mclk);
   endtask
   always @(posedge done) cmp(rx, q.pop_front());
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim;
      end
   end
   initial begin
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      push;
      push;
      fork
         push;
         begin
            repeat (4) @(negedge mclk);
            cmp({15'h0, rdy}, 16'h0000);
            frame(2'h2, 3'h0);
         end
      join
      for (int i = 1; i < 9; i++) begin
         push;
         frame(2'h1, i[2:0]);
      end
      // a word was always buffered ahead, so no shift may have starved
      cmp({15'h0, lost}, 16'h0000);
      end_sim;
   end
endmodule
`default_nettype wire
